// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end
module tb_top;
  logic       clk_sys = 1'b0;
  logic       rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       osc_in;
  logic       glob_en;
  logic       cmp_ack;
  logic       ovf_ack;
  logic       pin_dir;
  logic       pin;
  logic       oe;
  logic       ovr;
  logic       cmp_irq;
  logic       ovf_irq;
  logic       osc_en;
  logic       ext_en;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic       rd_prev = 1'b0;
  logic [15:0] seed = 16'hBAB1;
  int         mismatches = 0;
  int         check_count = 0;
  int         dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  localparam logic [2:0] A_CTL = timer8_pkg::ADDR_CONTROL_A;
  localparam logic [2:0] A_CNT = timer8_pkg::ADDR_COUNT;
  localparam logic [2:0] A_CMP = timer8_pkg::ADDR_COMPARE;
  localparam logic [2:0] A_ASY = timer8_pkg::ADDR_ASYNC;
  localparam logic [2:0] A_MSK = timer8_pkg::ADDR_IRQ_MASK;
  localparam logic [2:0] A_FLG = timer8_pkg::ADDR_IRQ_FLAGS;
  localparam logic [2:0] A_GEN = timer8_pkg::ADDR_GENERAL;

  async_timer8 i_async_timer8 (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_osc_input(osc_in), .global_irq_enable(glob_en), .compare_vector_ack(cmp_ack),
    .overflow_vector_ack(ovf_ack), .pin_dir_bit(pin_dir), .compare_output_pin(pin),
    .compare_output_oe(oe), .pin_override(ovr), .compare_irq_req(cmp_irq),
    .overflow_irq_req(ovf_irq), .osc_enable(osc_en), .ext_clock_input_enable(ext_en));

  always #5 clk_sys = ~clk_sys;

  // 16-bit xorshift keeps the random data reproducible
  function automatic logic [15:0] xs(input logic [15:0] s);
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    return s ^ (s << 8);
  endfunction

  // strobes are followed by one idle edge so no signal is assigned twice at once
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic osc_pulse;
    osc_in <= 1'b1;
    idle(8);
    osc_in <= 0;
    idle(8);
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // read answers stand in the cycle after the strobe; sample them mid-cycle
  always @(negedge clk_sys)
  begin
    // pop once: the macro names its expected value twice
    if (rd_prev)
    begin
      exp_v = exp_q.pop_front();
      `CHECK("read data", exp_v, reg_rdata)
    end
    rd_prev = reg_rd;
  end

  // hang guard, well beyond the few thousand cycles the run needs
  initial
  begin
    idle(20000);
    mismatches++;
    end_sim();
  end

  initial
  begin
    {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 3'h0, 8'h00, 1'b0, 1'b0};
    {osc_in, glob_en, cmp_ack, ovf_ack, pin_dir} = 5'h00;
    idle(6);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(i[2:0], 8'h00);
    $display("test reset done");
    // stopped timer: counter and compare read back what was written
    repeat (4)
    begin
      seed = xs(seed);
      wr(A_CNT, seed[7:0]);
      wr(A_CMP, seed[15:8]);
      rd(A_CNT, seed[7:0]);
      rd(A_CMP, seed[15:8]);
    end
    $display("test readback done");
    // normal mode, toggle: one match at F2, then the wrap
    wr(A_MSK, 8'h03);
    glob_en <= 1'b1;
    pin_dir <= 1'b1;
    wr(A_CNT, 8'hF0);
    wr(A_CMP, 8'hF2);
    wr(A_CTL, 8'h11);
    idle(20);
    wr(A_CTL, 8'h10);
    #1;
    `CHECK("pin", 1'b1, pin)
    `CHECK("oe", 1'b1, oe)
    `CHECK("cmp irq", 1'b1, cmp_irq)
    `CHECK("ovf irq", 1'b1, ovf_irq)
    @(posedge clk_sys);
    rd(A_FLG, 8'h03);
    wr(A_FLG, 8'h02);
    rd(A_FLG, 8'h01);
    ovf_ack <= 1'b1;
    idle(1);
    ovf_ack <= 1'b0;
    idle(1);
    rd(A_FLG, 8'h00);
    rd(A_CTL, 8'h10);
    pin_dir <= 1'b0;
    idle(3);
    #1;
    `CHECK("oe", 1'b0, oe)
    `CHECK("override", 1'b1, ovr)
    @(posedge clk_sys);
    $display("test normal done");
    // fast PWM non-inverting: high after bottom, low after match at 80
    pin_dir <= 1'b1;
    wr(A_CNT, 8'h10);
    wr(A_CMP, 8'h80);
    wr(A_CTL, 8'h69);
    idle(272);
    #1;
    `CHECK("pwm pin", 1'b1, pin)
    idle(128);
    #1;
    `CHECK("pwm pin", 1'b0, pin)
    @(posedge clk_sys);
    $display("test fast pwm done");
    // phase PWM clear mode: low after the up match, high after the down match
    wr(A_CTL, 8'h00);
    wr(A_CNT, 8'h30);
    wr(A_CMP, 8'h40);
    wr(A_FLG, 8'h03);
    wr(A_CTL, 8'h61);
    idle(450);
    #1;
    `CHECK("phase pin", 1'b1, pin)
    @(posedge clk_sys);
    rd(A_FLG, 8'h02);
    idle(80);
    #1;
    `CHECK("phase pin", 1'b0, pin)
    @(posedge clk_sys);
    rd(A_FLG, 8'h03);
    $display("test phase pwm done");
    // every prescaled select gives three ticks in three and a half periods
    for (int s = 2; s < 8; s++)
    begin
      wr(A_CTL, 8'h00);
      wr(A_CNT, 8'h00);
      // clear the prescaler before selecting, so no stray tick slips in
      wr(A_GEN, 8'h02);
      wr(A_CTL, {5'h00, s[2:0]});
      idle(dv[s] * 3 + dv[s] / 2);
      rd(A_CNT, 8'h03);
    end
    $display("test prescaler done");
    // async: writes sit in holding registers until an oscillator edge
    wr(A_CTL, 8'h00);
    wr(A_ASY, 8'h08);
    idle(2);
    #1;
    `CHECK("osc enable", 1'b1, osc_en)
    `CHECK("ext enable", 1'b0, ext_en)
    @(posedge clk_sys);
    wr(A_CNT, 8'h33);
    wr(A_CMP, 8'h5A);
    wr(A_CTL, 8'h00);
    wr(A_GEN, 8'h02);
    rd(A_ASY, 8'h0F);
    rd(A_GEN, 8'h02);
    rd(A_CMP, 8'h5A);
    osc_pulse();
    rd(A_ASY, 8'h08);
    rd(A_GEN, 8'h00);
    rd(A_CNT, 8'h33);
    wr(A_ASY, 8'h18);
    idle(2);
    #1;
    `CHECK("ext enable", 1'b1, ext_en)
    `CHECK("osc enable", 1'b0, osc_en)
    @(posedge clk_sys);
    glob_en <= 1'b0;
    idle(2);
    $display("test async done");
    end_sim();
  end
endmodule
bind async_timer8 timer8_monitor i_timer8_monitor (.clk_sys(clk_sys), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_irq_enable(global_irq_enable), .pin_dir_bit(pin_dir_bit),
  .compare_output_oe(compare_output_oe), .pin_override(pin_override),
  .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req),
  .osc_enable(osc_enable), .ext_clock_input_enable(ext_clock_input_enable));
`default_nettype wire

// *** bench/timer8_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
// port-level checker; every property is held off while reset is high
module timer8_monitor
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [2:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       global_irq_enable,
  input wire logic       pin_dir_bit,
  input wire logic       compare_output_oe,
  input wire logic       pin_override,
  input wire logic       compare_irq_req,
  input wire logic       overflow_irq_req,
  input wire logic       osc_enable,
  input wire logic       ext_clock_input_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // driver needs a live mode in the same cycle and the direction bit one cycle back
  oe_needs_dir_a: assert property (
    compare_output_oe |-> $past(pin_dir_bit) && pin_override)
    else $error("driver enabled without direction bit or mode");
  dir_gives_oe_a: assert property (
    pin_override && $past(pin_dir_bit) |-> compare_output_oe)
    else $error("driver off although mode and direction are set");
  // interrupt requests drop once the global enable is gone
  cmp_irq_gate_a: assert property (
    compare_irq_req |-> $past(global_irq_enable))
    else $error("compare request without global enable");
  ovf_irq_gate_a: assert property (
    !global_irq_enable |=> !overflow_irq_req)
    else $error("overflow request without global enable");
  // crystal and external buffer never run together
  clock_excl_a: assert property (
    !(osc_enable && ext_clock_input_enable))
    else $error("oscillator and external input both enabled");
  // clock path only moves after a write to the async register
  clock_src_a: assert property (
    $changed(osc_enable) || $changed(ext_clock_input_enable) |->
    $past(reg_wr && reg_addr == timer8_pkg::ADDR_ASYNC) ||
    $past(reg_wr && reg_addr == timer8_pkg::ADDR_ASYNC, 2))
    else $error("clock path changed without a write");
  // read data is zero outside the answer cycle and for the unused index
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero while idle");
  unmapped_rd_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped index returned data");
endmodule
`default_nettype wire

// *** design/async_timer8.sv ***
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none

module async_timer8
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_osc_input,
  input  wire logic       global_irq_enable,
  input  wire logic       compare_vector_ack,
  input  wire logic       overflow_vector_ack,
  input  wire logic       pin_dir_bit,
  output logic            compare_output_pin,
  output logic            compare_output_oe,
  output logic            pin_override,
  output logic            compare_irq_req,
  output logic            overflow_irq_req,
  output logic            osc_enable,
  output logic            ext_clock_input_enable
);

  // register state
  timer8_pkg::control_a_t ctrl_tmp_r;
  timer8_pkg::control_a_t ctrl_act_r;
  logic [7:0]  cmp_tmp_r;
  logic [7:0]  cmp_act_r;
  logic [7:0]  count_tmp_r;
  logic [7:0]  count_r;
  logic [7:0]  count_nxt;
  logic        dir_up_r;
  logic        dir_up_nxt;
  logic        block_r;
  logic        ext_clk_r;
  logic        async_r;
  logic        count_busy_r;
  logic        cmp_busy_r;
  logic        ctrl_busy_r;
  logic        cmp_ie_r;
  logic        ovf_ie_r;
  logic        cmp_flag_r;
  logic        ovf_flag_r;
  logic        sync_hold_r;
  logic        pre_clr_r;
  logic [9:0]  pre_r;
  logic        wave_r;
  logic        wave_nxt;
  logic [7:0]  rdata_nxt;
  logic        osc_s1_r;
  logic        osc_s2_r;
  logic        osc_s3_r;
  logic        osc_lvl_r;

  // oscillator pin: three flops, a change counts once the last two agree
  wire osc_stable = (osc_s2_r == osc_s3_r);
  wire osc_rise   = osc_stable & osc_s3_r & ~osc_lvl_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      osc_lvl_r <= 1'b0;
    end
    else
    begin
      osc_s1_r <= timer_osc_input;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      if (osc_stable)
        osc_lvl_r <= osc_s3_r;
    end
  end

  // source clock: every system cycle, or each oscillator rising edge
  wire src_tick = async_r ? osc_rise : 1'b1;

  // register port decode
  wire wr_ctrl  = reg_wr & (reg_addr == timer8_pkg::ADDR_CONTROL_A);
  wire wr_count = reg_wr & (reg_addr == timer8_pkg::ADDR_COUNT);
  wire wr_cmp   = reg_wr & (reg_addr == timer8_pkg::ADDR_COMPARE);
  wire wr_async = reg_wr & (reg_addr == timer8_pkg::ADDR_ASYNC);
  wire wr_mask  = reg_wr & (reg_addr == timer8_pkg::ADDR_IRQ_MASK);
  wire wr_flags = reg_wr & (reg_addr == timer8_pkg::ADDR_IRQ_FLAGS);
  wire wr_gen   = reg_wr & (reg_addr == timer8_pkg::ADDR_GENERAL);

  // async loads happen on a source edge while the busy flag is up
  wire load_count = async_r & src_tick & count_busy_r;
  wire load_cmp   = async_r & src_tick & cmp_busy_r;
  wire load_ctrl  = async_r & src_tick & ctrl_busy_r;

  // prescaler and clock select
  wire [1:0] wgm = {ctrl_act_r.wgm_hi, ctrl_act_r.wgm_lo};
  wire [2:0] cs  = ctrl_act_r.clock_sel;
  logic [9:0] pre_mask;
  always_comb
  begin
    case (cs)
      3'h2:    pre_mask = timer8_pkg::PRE_MASK_8;
      3'h3:    pre_mask = timer8_pkg::PRE_MASK_32;
      3'h4:    pre_mask = timer8_pkg::PRE_MASK_64;
      3'h5:    pre_mask = timer8_pkg::PRE_MASK_128;
      3'h6:    pre_mask = timer8_pkg::PRE_MASK_256;
      default: pre_mask = timer8_pkg::PRE_MASK_1024;
    endcase
  end

  // the prescaler stays in reset while the clear bit stands
  wire pre_run    = src_tick & ~pre_clr_r;
  wire pre_hit    = ((pre_r & pre_mask) == pre_mask);
  wire timer_tick = (cs == timer8_pkg::CS_DIRECT) ? src_tick
                  : (cs != timer8_pkg::CS_STOP) & pre_run & pre_hit;
  wire tick_cnt   = timer_tick & ~load_count;

  // mode decode
  wire is_phase  = (wgm == timer8_pkg::WGM_PHASE_PWM);
  wire is_fast   = (wgm == timer8_pkg::WGM_FAST_PWM);
  wire is_ctc    = (wgm == timer8_pkg::WGM_CLEAR_MATCH);
  wire is_pwm    = is_phase | is_fast;
  wire [7:0] top = is_ctc ? cmp_act_r : timer8_pkg::COUNT_MAX;
  wire at_top    = (count_r == top);
  wire at_max    = (count_r == timer8_pkg::COUNT_MAX);
  wire at_bottom = (count_r == timer8_pkg::COUNT_BOTTOM);
  wire [1:0] com = ctrl_act_r.com;

  // compare match, blocked for one tick after a counter write
  wire match     = tick_cnt & (count_r == cmp_act_r) & ~block_r;
  wire pwm_top_case = is_pwm & com[1] & (cmp_act_r == top);
  wire wave_match = match & ~pwm_top_case;
  wire wave_top   = tick_cnt & pwm_top_case & at_top;

  // overflow: at max in up-only modes, at the bottom turn in phase PWM
  wire ovf_event = tick_cnt & (is_phase ? (at_bottom & ~dir_up_r) : at_max);

  // counting sequence
  always_comb
  begin
    count_nxt  = count_r;
    dir_up_nxt = dir_up_r;
    if (tick_cnt)
    begin
      if (is_phase)
      begin
        if (dir_up_r & at_max)
        begin
          dir_up_nxt = 1'b0;
          count_nxt  = 8'(count_r - 8'h01);
        end
        else if (~dir_up_r & at_bottom)
        begin
          dir_up_nxt = 1'b1;
          count_nxt  = 8'(count_r + 8'h01);
        end
        else if (dir_up_r)
          count_nxt = 8'(count_r + 8'h01);
        else
          count_nxt = 8'(count_r - 8'h01);
      end
      else if (is_ctc & at_top)
        count_nxt = timer8_pkg::COUNT_BOTTOM;
      else
        count_nxt = 8'(count_r + 8'h01);
    end
  end

  // waveform on the compare pin; in fast PWM the bottom action wins
  always_comb
  begin
    wave_nxt = wave_r;
    if (is_fast)
    begin
      if (tick_cnt & at_top & (com == timer8_pkg::COM_CLEAR))
        wave_nxt = 1'b1;
      else if (tick_cnt & at_top & (com == timer8_pkg::COM_SET))
        wave_nxt = 1'b0;
      else if (wave_match & (com == timer8_pkg::COM_CLEAR))
        wave_nxt = 1'b0;
      else if (wave_match & (com == timer8_pkg::COM_SET))
        wave_nxt = 1'b1;
    end
    else if (is_phase)
    begin
      if ((wave_match | wave_top) & com[1])
        wave_nxt = (com == timer8_pkg::COM_SET) ? dir_up_r : ~dir_up_r;
    end
    else
    begin
      case (com)
        timer8_pkg::COM_TOGGLE: if (match) wave_nxt = ~wave_r;
        timer8_pkg::COM_CLEAR:  if (match) wave_nxt = 1'b0;
        timer8_pkg::COM_SET:    if (match) wave_nxt = 1'b1;
        default:                wave_nxt = wave_r;
      endcase
    end
  end

  // flag clears: vector ack or a one written; hardware set wins
  wire cmp_clr = compare_vector_ack
               | (wr_flags & reg_wdata[timer8_pkg::COMPARE_IRQ_BIT]);
  wire ovf_clr = overflow_vector_ack
               | (wr_flags & reg_wdata[timer8_pkg::OVERFLOW_IRQ_BIT]);

  // prescaler clear self-clears while the sync hold bit is low: at once in sync mode, after a source edge in async
  wire pre_clr_set  = wr_gen & reg_wdata[timer8_pkg::PRESCALER_CLR_BIT];
  wire pre_clr_done = pre_clr_r & ~sync_hold_r & (async_r ? src_tick : 1'b1);

  // read mux, answered one cycle after the strobe
  always_comb
  begin
    case (reg_addr)
      timer8_pkg::ADDR_CONTROL_A: rdata_nxt = {1'b0, ctrl_tmp_r[6:0]};
      timer8_pkg::ADDR_COUNT:     rdata_nxt = count_r;
      timer8_pkg::ADDR_COMPARE:   rdata_nxt = cmp_tmp_r;
      timer8_pkg::ADDR_ASYNC:     rdata_nxt = {3'h0, ext_clk_r, async_r,
                                               count_busy_r, cmp_busy_r, ctrl_busy_r};
      timer8_pkg::ADDR_IRQ_MASK:  rdata_nxt = {6'h00, cmp_ie_r, ovf_ie_r};
      timer8_pkg::ADDR_IRQ_FLAGS: rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
      timer8_pkg::ADDR_GENERAL:   rdata_nxt = {sync_hold_r, 5'h00, pre_clr_r, 1'b0};
      default:                    rdata_nxt = timer8_pkg::BYTE_RESET;
    endcase
  end

  // software-visible configuration and holding registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_tmp_r  <= timer8_pkg::CONTROL_A_RESET;
      cmp_tmp_r   <= timer8_pkg::BYTE_RESET;
      count_tmp_r <= timer8_pkg::BYTE_RESET;
      ext_clk_r   <= 1'b0;
      async_r     <= 1'b0;
      cmp_ie_r    <= 1'b0;
      ovf_ie_r    <= 1'b0;
      sync_hold_r <= 1'b0;
      reg_rdata   <= timer8_pkg::BYTE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_tmp_r <= timer8_pkg::control_a_t'({1'b0, reg_wdata[6:0]});
      if (wr_cmp)
        cmp_tmp_r <= reg_wdata;
      if (wr_count)
        count_tmp_r <= reg_wdata;
      if (wr_async)
      begin
        ext_clk_r <= reg_wdata[timer8_pkg::EXT_CLOCK_BIT];
        async_r   <= reg_wdata[timer8_pkg::ASYNC_SEL_BIT];
      end
      if (wr_mask)
      begin
        cmp_ie_r <= reg_wdata[timer8_pkg::COMPARE_IRQ_BIT];
        ovf_ie_r <= reg_wdata[timer8_pkg::OVERFLOW_IRQ_BIT];
      end
      if (wr_gen)
        sync_hold_r <= reg_wdata[timer8_pkg::SYNC_HOLD_BIT];
      reg_rdata <= reg_rd ? rdata_nxt : timer8_pkg::BYTE_RESET;
    end
  end

  // busy flags: a write in async mode sets, the load clears; write wins
  // a write while busy is the caller's fault and may corrupt the value
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_busy_r <= 1'b0;
      cmp_busy_r   <= 1'b0;
      ctrl_busy_r  <= 1'b0;
    end
    else
    begin
      count_busy_r <= (wr_count & async_r) | (count_busy_r & ~load_count);
      cmp_busy_r   <= (wr_cmp & async_r) | (cmp_busy_r & ~load_cmp);
      ctrl_busy_r  <= (wr_ctrl & async_r) | (ctrl_busy_r & ~load_ctrl);
    end
  end

  // active compare and control: direct in sync mode, from holding in async
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_act_r  <= timer8_pkg::BYTE_RESET;
      ctrl_act_r <= timer8_pkg::CONTROL_A_RESET;
    end
    else
    begin
      if (wr_cmp & ~async_r)
        cmp_act_r <= reg_wdata;
      else if (load_cmp)
        cmp_act_r <= cmp_tmp_r;
      if (wr_ctrl & ~async_r)
        ctrl_act_r <= timer8_pkg::control_a_t'({1'b0, reg_wdata[6:0]});
      else if (load_ctrl)
        ctrl_act_r <= ctrl_tmp_r;
    end
  end

  // counter, direction and match block
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_r  <= timer8_pkg::BYTE_RESET;
      dir_up_r <= 1'b1;
      block_r  <= 1'b0;
    end
    else
    begin
      dir_up_r <= dir_up_nxt;
      if (wr_count & ~async_r)
      begin
        count_r <= reg_wdata;
        block_r <= 1'b1;
      end
      else if (load_count)
      begin
        count_r <= count_tmp_r;
        block_r <= 1'b1;
      end
      else
      begin
        count_r <= count_nxt;
        if (tick_cnt)
          block_r <= 1'b0;
      end
    end
  end

  // prescaler and its clear bit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pre_r     <= 10'h000;
      pre_clr_r <= 1'b0;
    end
    else
    begin
      pre_clr_r <= pre_clr_set | (pre_clr_r & ~pre_clr_done);
      if (pre_clr_r)
        pre_r <= 10'h000;
      else if (pre_run)
        pre_r <= 10'(pre_r + 10'h001);
    end
  end

  // interrupt flags and registered requests
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_flag_r       <= 1'b0;
      ovf_flag_r       <= 1'b0;
      compare_irq_req  <= 1'b0;
      overflow_irq_req <= 1'b0;
    end
    else
    begin
      cmp_flag_r       <= match | (cmp_flag_r & ~cmp_clr);
      ovf_flag_r       <= ovf_event | (ovf_flag_r & ~ovf_clr);
      compare_irq_req  <= cmp_ie_r & global_irq_enable & cmp_flag_r;
      overflow_irq_req <= ovf_ie_r & global_irq_enable & ovf_flag_r;
    end
  end

  // pin side: waveform, override and driver enable; oscillator controls
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wave_r                 <= 1'b0;
      compare_output_pin     <= 1'b0;
      compare_output_oe      <= 1'b0;
      pin_override           <= 1'b0;
      osc_enable             <= 1'b0;
      ext_clock_input_enable <= 1'b0;
    end
    else
    begin
      wave_r                 <= wave_nxt;
      compare_output_pin     <= wave_nxt;
      pin_override           <= (com != timer8_pkg::COM_OFF);
      compare_output_oe      <= (com != timer8_pkg::COM_OFF) & pin_dir_bit;
      osc_enable             <= async_r & ~ext_clk_r;
      ext_clock_input_enable <= async_r & ext_clk_r;
    end
  end

endmodule

`default_nettype wire

// *** design/timer8_pkg.sv ***
package timer8_pkg;

  // register indexes on the plain register port
  localparam logic [2:0] ADDR_CONTROL_A   = 3'h0;
  localparam logic [2:0] ADDR_COUNT       = 3'h1;
  localparam logic [2:0] ADDR_COMPARE     = 3'h2;
  localparam logic [2:0] ADDR_ASYNC       = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK    = 3'h4;
  localparam logic [2:0] ADDR_IRQ_FLAGS   = 3'h5;
  localparam logic [2:0] ADDR_GENERAL     = 3'h6;

  // async status/control bit positions
  localparam int EXT_CLOCK_BIT      = 4;
  localparam int ASYNC_SEL_BIT      = 3;
  localparam int COUNT_BUSY_BIT     = 2;
  localparam int COMPARE_BUSY_BIT   = 1;
  localparam int CONTROL_BUSY_BIT   = 0;

  // mask / flag bit positions
  localparam int COMPARE_IRQ_BIT    = 1;
  localparam int OVERFLOW_IRQ_BIT   = 0;

  // general control bit positions
  localparam int SYNC_HOLD_BIT      = 7;
  localparam int PRESCALER_CLR_BIT  = 1;

  // control register A layout, msb first
  typedef struct packed {
    logic       force_cmp;   // dropped on write, reads zero
    logic       wgm_lo;
    logic [1:0] com;
    logic       wgm_hi;
    logic [2:0] clock_sel;
  } control_a_t;

  localparam control_a_t CONTROL_A_RESET = control_a_t'(8'h00);
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam logic [7:0] COUNT_MAX       = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM    = 8'h00;

  // waveform modes {wgm_hi, wgm_lo}
  localparam logic [1:0] WGM_NORMAL      = 2'h0;
  localparam logic [1:0] WGM_PHASE_PWM   = 2'h1;
  localparam logic [1:0] WGM_CLEAR_MATCH = 2'h2;
  localparam logic [1:0] WGM_FAST_PWM    = 2'h3;

  // compare output modes
  localparam logic [1:0] COM_OFF         = 2'h0;
  localparam logic [1:0] COM_TOGGLE      = 2'h1;
  localparam logic [1:0] COM_CLEAR       = 2'h2;
  localparam logic [1:0] COM_SET         = 2'h3;

  // prescaler: tick when the masked low bits are all ones
  localparam int PRESCALE_W = 10;
  localparam logic [9:0] PRE_MASK_8      = 10'h007;
  localparam logic [9:0] PRE_MASK_32     = 10'h01F;
  localparam logic [9:0] PRE_MASK_64     = 10'h03F;
  localparam logic [9:0] PRE_MASK_128    = 10'h07F;
  localparam logic [9:0] PRE_MASK_256    = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024   = 10'h3FF;

  localparam logic [2:0] CS_STOP         = 3'h0;
  localparam logic [2:0] CS_DIRECT       = 3'h1;

endpackage
